// File: logic/trim_port_pkg.sv
// Shared constants of the two-wire trim memory serial port.
// Assumes both ends run their own logic from a 250 MHz reference clock.
package trim_port_pkg;

  // Reference clock rate
  localparam int unsigned CLK_MHZ = 250;

  // Durations as printed, in microseconds
  localparam int unsigned ENTRY_TIME_US    = 1000;
  localparam int unsigned EXIT_TIME_US     = 500;
  localparam int unsigned NV_WRITE_TIME_US = 5000;
  localparam int unsigned BATCH_TIME_US    = 10000;
  localparam int unsigned REG_WRITE_TIME_US = 10;

  // Microseconds to whole reference clock cycles (exact at integer rates)
  function automatic int unsigned cycles_of(input int unsigned time_us);
    cycles_of = time_us * CLK_MHZ;
  endfunction : cycles_of

  localparam int unsigned ENTRY_CYCLES    = cycles_of(ENTRY_TIME_US);
  localparam int unsigned EXIT_CYCLES     = cycles_of(EXIT_TIME_US);
  localparam int unsigned NV_WRITE_CYCLES = cycles_of(NV_WRITE_TIME_US);
  localparam int unsigned BATCH_CYCLES    = cycles_of(BATCH_TIME_US);
  localparam int unsigned REG_WRITE_CYCLES = cycles_of(REG_WRITE_TIME_US);

  // Extra hold beyond a threshold, covering the far end's synchroniser
  localparam int unsigned MARGIN_CYCLES = 8;
  // Default half period of the serial clock, in reference cycles
  localparam int unsigned HALF_CYCLES   = 16;
  localparam int unsigned TIMER_W       = 24;

  // Frame layout: opcode, address, data, sent highest bit first
  localparam int unsigned FRAME_BITS  = 16;
  localparam int unsigned HEADER_BITS = 8;
  localparam logic [4:0]  FRAME_LAST  = 5'h10;
  localparam logic [4:0]  HEADER_LAST = 5'h08;

  // Opcodes
  localparam logic [2:0] OP_NV_READ    = 3'h6;
  localparam logic [2:0] OP_NV_WRITE   = 3'h5;
  localparam logic [2:0] OP_CTRL_READ  = 3'h2;
  localparam logic [2:0] OP_CTRL_WRITE = 3'h1;

  // Special addresses of a non-volatile write
  localparam logic [4:0] BATCH_ADDR = 5'h1F;
  localparam logic [4:0] SKIP_ADDR  = 5'h1E;

  // Memory shape and contents after reset
  localparam int unsigned MEM_DEPTH = 32;
  localparam logic [7:0]  MEM_RESET = 8'h00;

endpackage : trim_port_pkg

// File: logic/trim_link_if.sv
// Two-wire link between the calibration host and the trim port device.
// Assumes the data line is pulled high when neither end drives it.
`timescale 1ns/1ps
`default_nettype none
interface trim_link_if;
  logic cfg_serial_clock_pin;  // Serial clock, made by the host
  logic host_sdio_o;           // Host data out
  logic host_sdio_oe;          // Host drives the data line
  logic dev_sdio_o;            // Device data out
  logic dev_sdio_oe;           // Device drives the data line
  logic dev_analog_en;         // Shared pin carries the analog output
  logic serial_data_io;        // Resolved level of the shared pin

  // Wire level from the enables, weak pull-up when released
  assign serial_data_io = dev_sdio_oe ? dev_sdio_o :
                          (host_sdio_oe ? host_sdio_o : 1'b1);

  modport device (
    input  cfg_serial_clock_pin,
    input  serial_data_io,
    output dev_sdio_o,
    output dev_sdio_oe,
    output dev_analog_en
  );

  modport host (
    output cfg_serial_clock_pin,
    output host_sdio_o,
    output host_sdio_oe,
    input  serial_data_io,
    input  dev_analog_en
  );
endinterface : trim_link_if
`default_nettype wire

// File: logic/trim_port_device.sv
// Device end of the trim memory serial port: mode detection, frame decode,
// trim and control storage. Assumes the host keeps each serial clock phase
// at least 16 reference cycles long, so every edge is seen after syncing.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Clock high past entry time: serial mode
// - Clock low past exit time: analog mode
// - Sample data on serial clock rising edge
// - Frames are 16 bits: opcode, address, data
// - Host sends highest bit first
// - Read data presented from ninth edge
// - Opcode 110 reads trim memory
// - Opcode 101 programs trim memory
// - Write to 1Fh fills all but 1Eh
// - Opcode 010 reads control register
// - Opcode 001 writes control register
// - Host issues only the four opcodes
// - Host holds clock for single write
// - Host holds clock for batch write
// - Host holds clock for register write
module trim_port_device #(
  parameter int unsigned ENTRY_CYCLES = trim_port_pkg::ENTRY_CYCLES,
  parameter int unsigned EXIT_CYCLES  = trim_port_pkg::EXIT_CYCLES
) (
  input  wire logic       ref_clk_i,       // Reference clock
  input  wire logic       resetn_i,        // Synchronous reset, active low
  trim_link_if.device     link,            // Two-wire link
  input  wire logic [4:0] trim_rd_addr_i,  // Trim memory lookup address
  output logic      [7:0] trim_rd_data_o,  // Trim memory lookup data
  input  wire logic [4:0] ctrl_rd_addr_i,  // Control register lookup address
  output logic      [7:0] ctrl_rd_data_o,  // Control register lookup data
  output logic            serial_mode_o,   // Shared pin is in serial mode
  output logic            write_done_o     // Pulse: a write was committed
);

  localparam int unsigned TW = trim_port_pkg::TIMER_W;

  // Elaboration check on the timer width
  if (ENTRY_CYCLES == 0 || EXIT_CYCLES == 0 ||
      ENTRY_CYCLES >= (1 << TW) || EXIT_CYCLES >= (1 << TW)) begin : g_chk
    $error("trim_port_device: entry or exit count out of range");
  end

  localparam logic [TW-1:0] ENTRY_LIM = ENTRY_CYCLES[TW-1:0];
  localparam logic [TW-1:0] EXIT_LIM  = EXIT_CYCLES[TW-1:0];

  // Link domain: shift register clocked by the serial clock itself
  logic [15:0] lk_shift_reg;
  logic [15:0] lk_shift_next;

  // newest bit enters at the bottom, first bit ends on top
  always_comb
  begin
    lk_shift_next = {lk_shift_reg[14:0], link.serial_data_io};
  end

  always_ff @(posedge link.cfg_serial_clock_pin)
  begin
    lk_shift_reg <= lk_shift_next;
  end

  // Reference domain state
  logic          sck_meta_reg, sck_sync_reg, sck_prev_reg;
  logic [TW-1:0] dur_reg, dur_next;
  logic          mode_reg, mode_next;
  logic [4:0]    bit_reg, bit_next;
  logic [2:0]    op_reg, op_next;
  logic [4:0]    addr_reg, addr_next;
  logic [7:0]    out_reg, out_next;
  logic          oe_reg, oe_next;
  logic          done_reg, done_next;
  logic [7:0]    nv_reg   [trim_port_pkg::MEM_DEPTH];
  logic [7:0]    nv_next  [trim_port_pkg::MEM_DEPTH];
  logic [7:0]    ctl_reg  [trim_port_pkg::MEM_DEPTH];
  logic [7:0]    ctl_next [trim_port_pkg::MEM_DEPTH];
  logic          rise;

  // Serial clock pin through two flip-flops, then an edge detector
  always_ff @(posedge ref_clk_i)
  begin
    sck_meta_reg <= link.cfg_serial_clock_pin;
    sck_sync_reg <= sck_meta_reg;
    sck_prev_reg <= sck_sync_reg;
  end

  assign rise = sck_sync_reg & ~sck_prev_reg;

  // Mode timing, frame decode and storage updates
  always_comb
  begin
    dur_next  = dur_reg;
    mode_next = mode_reg;
    bit_next  = bit_reg;
    op_next   = op_reg;
    addr_next = addr_reg;
    out_next  = out_reg;
    oe_next   = oe_reg;
    done_next = 1'b0;
    nv_next   = nv_reg;
    ctl_next  = ctl_reg;

    // Cycles since the synced clock last changed, saturating
    if (sck_sync_reg != sck_prev_reg)
    begin
      dur_next = '0;
    end
    else if (dur_reg != '1)
    begin
      dur_next = dur_reg + 1'b1;
    end

    if (!mode_reg)
    begin
      // entry after clock held high past the limit
      if (sck_sync_reg && dur_reg == ENTRY_LIM)
      begin
        mode_next = 1'b1;
        bit_next  = '0;
        oe_next   = 1'b0;
      end
    end
    else if (!sck_sync_reg && dur_reg == EXIT_LIM)
    begin
      // exit after clock held low past the limit
      // a partly received frame is dropped here
      mode_next = 1'b0;
      bit_next  = '0;
      oe_next   = 1'b0;
    end
    else if (rise)
    begin
      // count edges of one 16-bit frame
      bit_next = bit_reg + 1'b1;
      if (bit_next == trim_port_pkg::HEADER_LAST)
      begin
        op_next   = lk_shift_reg[7:5];
        addr_next = lk_shift_reg[4:0];
        // first read bit is on the line before edge nine
        // device takes the line for the data phase
        unique case (lk_shift_reg[7:5])
          trim_port_pkg::OP_NV_READ:
          begin
            out_next = nv_reg[lk_shift_reg[4:0]];
            oe_next  = 1'b1;
          end
          trim_port_pkg::OP_CTRL_READ:
          begin
            out_next = ctl_reg[lk_shift_reg[4:0]];
            oe_next  = 1'b1;
          end
          default:
          begin
            oe_next = 1'b0;
          end
        endcase
      end
      else if (bit_next == trim_port_pkg::FRAME_LAST)
      begin
        // commit only on the sixteenth edge
        bit_next = '0;
        // release the line as the frame ends
        oe_next  = 1'b0;
        unique case (op_reg)
          trim_port_pkg::OP_NV_WRITE:
          begin
            done_next = 1'b1;
            // batch write to all addresses but one
            if (addr_reg == trim_port_pkg::BATCH_ADDR)
            begin
              for (int i = 0; i < trim_port_pkg::MEM_DEPTH; i++)
              begin
                if (i[4:0] != trim_port_pkg::SKIP_ADDR)
                begin
                  nv_next[i] = lk_shift_reg[7:0];
                end
              end
            end
            else
            begin
              nv_next[addr_reg] = lk_shift_reg[7:0];
            end
          end
          trim_port_pkg::OP_CTRL_WRITE:
          begin
            ctl_next[addr_reg] = lk_shift_reg[7:0];
            done_next = 1'b1;
          end
          default:
          begin
            done_next = 1'b0;
          end
        endcase
      end
      else if (bit_reg >= trim_port_pkg::HEADER_LAST)
      begin
        // next read bit follows each sampled edge
        out_next = {out_reg[6:0], 1'b0};
      end
    end
  end

  // Registers of the reference domain
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      dur_reg  <= '0;
      mode_reg <= 1'b0;
      bit_reg  <= '0;
      op_reg   <= '0;
      addr_reg <= '0;
      out_reg  <= '0;
      oe_reg   <= 1'b0;
      done_reg <= 1'b0;
      for (int i = 0; i < trim_port_pkg::MEM_DEPTH; i++)
      begin
        nv_reg[i]  <= trim_port_pkg::MEM_RESET;
        ctl_reg[i] <= trim_port_pkg::MEM_RESET;
      end
    end
    else
    begin
      dur_reg  <= dur_next;
      mode_reg <= mode_next;
      bit_reg  <= bit_next;
      op_reg   <= op_next;
      addr_reg <= addr_next;
      out_reg  <= out_next;
      oe_reg   <= oe_next;
      done_reg <= done_next;
      nv_reg   <= nv_next;
      ctl_reg  <= ctl_next;
    end
  end

  // Lookup outputs for the analog side, registered
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      trim_rd_data_o <= '0;
      ctrl_rd_data_o <= '0;
    end
    else
    begin
      trim_rd_data_o <= nv_reg[trim_rd_addr_i];
      ctrl_rd_data_o <= ctl_reg[ctrl_rd_addr_i];
    end
  end

  // Pin and status outputs
  assign link.dev_sdio_o   = out_reg[7];
  assign link.dev_sdio_oe  = oe_reg;
  assign link.dev_analog_en = ~mode_reg;
  assign serial_mode_o     = mode_reg;
  assign write_done_o      = done_reg;

endmodule : trim_port_device
`default_nettype wire

// File: logic/trim_port_host.sv
// Host end of the trim memory serial port: runs one command per session,
// entering serial mode, sending a frame, holding for the write, exiting.
// Assumes the user holds command fields stable while cmd_valid_i is high.
`timescale 1ns/1ps
`default_nettype none
module trim_port_host #(
  parameter int unsigned ENTRY_CYCLES = trim_port_pkg::ENTRY_CYCLES,
  parameter int unsigned EXIT_CYCLES  = trim_port_pkg::EXIT_CYCLES,
  parameter int unsigned NV_CYCLES    = trim_port_pkg::NV_WRITE_CYCLES,
  parameter int unsigned BATCH_CYCLES = trim_port_pkg::BATCH_CYCLES,
  parameter int unsigned REG_CYCLES   = trim_port_pkg::REG_WRITE_CYCLES,
  parameter int unsigned HALF_CYCLES  = trim_port_pkg::HALF_CYCLES
) (
  input  wire logic       ref_clk_i,    // Reference clock
  input  wire logic       resetn_i,     // Synchronous reset, active low
  trim_link_if.host       link,         // Two-wire link
  input  wire logic       cmd_valid_i,  // Command request
  output logic            cmd_ready_o,  // Host idle, command taken
  input  wire logic [2:0] cmd_op_i,     // Opcode
  input  wire logic [4:0] cmd_addr_i,   // Address
  input  wire logic [7:0] cmd_wdata_i,  // Write data
  output logic            rsp_valid_o,  // Pulse: session finished
  output logic      [7:0] rsp_rdata_o   // Read data of the session
);

  localparam int unsigned TW = trim_port_pkg::TIMER_W;
  localparam int unsigned MG = trim_port_pkg::MARGIN_CYCLES;

  // Elaboration check: entry, single and batch write counts fit the timer, phases long enough to sync
  if (HALF_CYCLES < 16 || BATCH_CYCLES + MG >= (1 << TW) ||
      ENTRY_CYCLES + MG >= (1 << TW) || NV_CYCLES + MG >= (1 << TW)) begin : g_chk
    $error("trim_port_host: timing parameters out of range");
  end

  localparam logic [TW-1:0] ENTRY_LIM = TW'(ENTRY_CYCLES + MG);
  localparam logic [TW-1:0] EXIT_LIM  = TW'(EXIT_CYCLES + MG);
  localparam logic [TW-1:0] HALF_LIM  = TW'(HALF_CYCLES - 1);

  typedef enum logic [2:0] {H_IDLE, H_ENTER, H_LOW, H_HIGH, H_HOLD, H_EXIT} hstate_t;

  hstate_t       st_reg, st_next;
  logic [TW-1:0] tmr_reg, tmr_next;
  logic [TW-1:0] hold_reg, hold_next;
  logic [15:0]   word_reg, word_next;
  logic [4:0]    bit_reg, bit_next;
  logic          rd_reg, rd_next;
  logic [7:0]    rx_reg, rx_next;
  logic          sck_reg, sck_next;
  logic          sdo_reg, sdo_next;
  logic          soe_reg, soe_next;
  logic          rsp_reg, rsp_next;
  logic          sdi_meta_reg, sdi_sync_reg;

  // Data line through two flip-flops before use
  always_ff @(posedge ref_clk_i)
  begin
    sdi_meta_reg <= link.serial_data_io;
    sdi_sync_reg <= sdi_meta_reg;
  end

  // Session sequencer
  always_comb
  begin
    st_next   = st_reg;
    tmr_next  = tmr_reg + 1'b1;
    hold_next = hold_reg;
    word_next = word_reg;
    bit_next  = bit_reg;
    rd_next   = rd_reg;
    rx_next   = rx_reg;
    sck_next  = sck_reg;
    sdo_next  = sdo_reg;
    soe_next  = soe_reg;
    rsp_next  = 1'b0;
    unique case (st_reg)
      H_IDLE:
      begin
        tmr_next = '0;
        // undefined opcodes are answered at once and never sent
        if (cmd_valid_i && cmd_op_i != trim_port_pkg::OP_NV_READ &&
            cmd_op_i != trim_port_pkg::OP_NV_WRITE &&
            cmd_op_i != trim_port_pkg::OP_CTRL_READ &&
            cmd_op_i != trim_port_pkg::OP_CTRL_WRITE)
        begin
          rsp_next = 1'b1;
        end
        else if (cmd_valid_i)
        begin
          word_next = {cmd_op_i, cmd_addr_i, cmd_wdata_i};
          rd_next   = (cmd_op_i == trim_port_pkg::OP_NV_READ) ||
                      (cmd_op_i == trim_port_pkg::OP_CTRL_READ);
          // hold time chosen by the write kind
          if (cmd_op_i == trim_port_pkg::OP_NV_WRITE)
          begin
            hold_next = (cmd_addr_i == trim_port_pkg::BATCH_ADDR) ?
                        TW'(BATCH_CYCLES + MG) : TW'(NV_CYCLES + MG);
          end
          else
          begin
            hold_next = (cmd_op_i == trim_port_pkg::OP_CTRL_WRITE) ?
                        TW'(REG_CYCLES + MG) : HALF_LIM;
          end
          sck_next = 1'b1;
          bit_next = '0;
          st_next  = H_ENTER;
        end
      end
      H_ENTER, H_HIGH:
      begin
        // on a read, let go of the line one cycle after the eighth rise
        // before the device (three cycles behind its synchroniser) takes it
        if (st_reg == H_HIGH && tmr_reg == '0 && rd_reg &&
            bit_reg == trim_port_pkg::HEADER_LAST)
        begin
          soe_next = 1'b0;
        end
        if ((st_reg == H_ENTER && tmr_reg == ENTRY_LIM) ||
            (st_reg == H_HIGH && tmr_reg == HALF_LIM))
        begin
          tmr_next = '0;
          if (bit_reg == trim_port_pkg::FRAME_LAST)
          begin
            // Frame sent: release the line, keep the clock high
            soe_next = 1'b0;
            st_next  = H_HOLD;
          end
          else
          begin
            // present the next of 16 bits while clock is low
            // host releases the line after the header on a read
            sck_next  = 1'b0;
            sdo_next  = word_reg[15];
            word_next = {word_reg[14:0], 1'b0};
            soe_next  = !(rd_reg && bit_reg >= trim_port_pkg::HEADER_LAST);
            st_next   = H_LOW;
          end
        end
      end
      H_LOW:
      begin
        if (tmr_reg == HALF_LIM)
        begin
          tmr_next = '0;
          sck_next = 1'b1;
          bit_next = bit_reg + 1'b1;
          // read bits taken at edges nine to sixteen
          if (rd_reg && bit_reg >= trim_port_pkg::HEADER_LAST)
          begin
            rx_next = {rx_reg[6:0], sdi_sync_reg};
          end
          st_next = H_HIGH;
        end
      end
      H_HOLD:
      begin
        if (tmr_reg == hold_reg)
        begin
          // drop the clock to leave serial mode
          tmr_next = '0;
          sck_next = 1'b0;
          st_next  = H_EXIT;
        end
      end
      H_EXIT:
      begin
        if (tmr_reg == EXIT_LIM)
        begin
          rsp_next = 1'b1;
          st_next  = H_IDLE;
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      st_reg   <= H_IDLE;
      tmr_reg  <= '0;
      hold_reg <= '0;
      word_reg <= '0;
      bit_reg  <= '0;
      rd_reg   <= 1'b0;
      rx_reg   <= '0;
      sck_reg  <= 1'b0;
      sdo_reg  <= 1'b0;
      soe_reg  <= 1'b0;
      rsp_reg  <= 1'b0;
    end
    else
    begin
      st_reg   <= st_next;
      tmr_reg  <= tmr_next;
      hold_reg <= hold_next;
      word_reg <= word_next;
      bit_reg  <= bit_next;
      rd_reg   <= rd_next;
      rx_reg   <= rx_next;
      sck_reg  <= sck_next;
      sdo_reg  <= sdo_next;
      soe_reg  <= soe_next;
      rsp_reg  <= rsp_next;
    end
  end

  // Link and user outputs
  assign link.cfg_serial_clock_pin = sck_reg;
  assign link.host_sdio_o  = sdo_reg;
  assign link.host_sdio_oe = soe_reg;
  assign cmd_ready_o       = (st_reg == H_IDLE);
  assign rsp_valid_o       = rsp_reg;
  assign rsp_rdata_o       = rx_reg;

endmodule : trim_port_host
`default_nettype wire

// File: testbench/trim_link_monitor.sv
// Checker for the two-wire trim link, fed with the interface wires.
// Assumes both ends and the checker share the reference clock.
`timescale 1ns/1ps
`default_nettype none
module trim_link_monitor #(
  parameter int unsigned ENTRY_CYCLES = 200,
  parameter int unsigned EXIT_CYCLES  = 100
) (
  input wire logic ref_clk_i,             // Reference clock
  input wire logic resetn_i,              // Reset, active low
  input wire logic cfg_serial_clock_pin,  // Serial clock
  input wire logic host_sdio_oe,          // Host drives data
  input wire logic dev_sdio_oe,           // Device drives data
  input wire logic dev_analog_en          // Pin in analog mode
);
  logic [15:0] hi_reg, hi_next, lo_reg, lo_next;
  logic [4:0]  rise_reg, rise_next;
  logic        sck_reg, sck_next;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // Saturating run lengths of the clock, rises counted in serial mode
  always_comb
  begin
    hi_next   = !cfg_serial_clock_pin ? 16'h0000 : hi_reg + {15'h0000, ~&hi_reg};
    lo_next   = cfg_serial_clock_pin ? 16'h0000 : lo_reg + {15'h0000, ~&lo_reg};
    rise_next = dev_analog_en ? 5'h00 : rise_reg + {4'h0, cfg_serial_clock_pin & ~sck_reg};
    sck_next  = cfg_serial_clock_pin;
  end

  // Helper registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      hi_reg   <= 16'h0000;
      lo_reg   <= 16'h0000;
      rise_reg <= 5'h00;
      sck_reg  <= 1'b0;
    end
    else
    begin
      hi_reg   <= hi_next;
      lo_reg   <= lo_next;
      rise_reg <= rise_next;
      sck_reg  <= sck_next;
    end
  end

  sequence s_eighth_rise;
    cfg_serial_clock_pin && rise_reg == 5'h08;
  endsequence
  sequence s_last_rise;
    cfg_serial_clock_pin && rise_reg == 5'h10;
  endsequence

  a_no_contention: assert property (!(dev_sdio_oe && host_sdio_oe))
    else $error("both ends drive the data line");
  a_analog_quiet: assert property (dev_analog_en |-> !dev_sdio_oe)
    else $error("device drives data in analog mode");
  a_entry_guard: assert property ($fell(dev_analog_en) |->
    cfg_serial_clock_pin && hi_reg >= ENTRY_CYCLES)
    else $error("serial mode entered too early");
  a_entry_timely: assert property (cfg_serial_clock_pin && hi_reg == ENTRY_CYCLES + 8
    |-> ##[0:6] !dev_analog_en)
    else $error("serial mode not entered");
  a_exit_guard: assert property ($rose(dev_analog_en) |->
    !cfg_serial_clock_pin && lo_reg >= EXIT_CYCLES)
    else $error("serial mode left too early");
  a_exit_timely: assert property (!cfg_serial_clock_pin && lo_reg == EXIT_CYCLES + 8
    |-> ##[0:6] dev_analog_en)
    else $error("analog output not restored");
  a_read_start: assert property ($rose(dev_sdio_oe) |-> s_eighth_rise)
    else $error("read drive not after eighth rise");
  a_read_end: assert property ($fell(dev_sdio_oe) |-> s_last_rise)
    else $error("read drive not released at frame end");
  a_read_holds: assert property ($rose(dev_sdio_oe) |-> dev_sdio_oe [*8])
    else $error("read drive glitched");
endmodule : trim_link_monitor
`default_nettype wire

// File: testbench/tb.sv
// Bench joining host and device ends over the link, judging both sides.
// Assumes one reference clock and shortened mode and write timers.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned ENT = 200;
  localparam int unsigned EXT = 100;
  logic        ref_clk_i, resetn_i, cmd_valid_i, cmd_ready_o, rsp_valid_o;
  logic        serial_mode_o, write_done_o, sck_q, seen_mode, seen_done;
  logic [2:0]  cmd_op_i;
  logic [4:0]  cmd_addr_i, trim_rd_addr_i, ctrl_rd_addr_i;
  logic [7:0]  cmd_wdata_i, rsp_rdata_o, trim_rd_data_o, ctrl_rd_data_o, nbits;
  logic [15:0] frame;
  int          n_mismatch = 0;
  int          checks = 0;

  trim_link_if link ();
  trim_port_host #(.ENTRY_CYCLES(ENT), .EXIT_CYCLES(EXT), .NV_CYCLES(300),
    .BATCH_CYCLES(600), .REG_CYCLES(50), .HALF_CYCLES(16)) i_trim_port_host (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link.host),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i),
    .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o));
  trim_port_device #(.ENTRY_CYCLES(ENT), .EXIT_CYCLES(EXT)) i_trim_port_device (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link.device),
    .trim_rd_addr_i(trim_rd_addr_i), .trim_rd_data_o(trim_rd_data_o),
    .ctrl_rd_addr_i(ctrl_rd_addr_i), .ctrl_rd_data_o(ctrl_rd_data_o),
    .serial_mode_o(serial_mode_o), .write_done_o(write_done_o));
  trim_link_monitor #(.ENTRY_CYCLES(ENT), .EXIT_CYCLES(EXT)) i_trim_link_monitor (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .cfg_serial_clock_pin(link.cfg_serial_clock_pin), .host_sdio_oe(link.host_sdio_oe),
    .dev_sdio_oe(link.dev_sdio_oe), .dev_analog_en(link.dev_analog_en));

  // Reference clock, 4 ns period
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // Wire sniffer: shared line captured at each serial clock rise in serial mode
  always @(posedge ref_clk_i)
  begin
    sck_q <= link.cfg_serial_clock_pin;
    if (link.cfg_serial_clock_pin && !sck_q && !link.dev_analog_en)
    begin
      frame <= {frame[14:0], link.serial_data_io};
      nbits <= nbits + 8'h01;
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // One session; lo is the expected data byte on the wire
  task automatic run(input logic [2:0] op, input logic [4:0] addr,
                     input logic [7:0] wd, input logic [7:0] lo, input logic wr);
    int i;
    @(posedge ref_clk_i);
    cmd_op_i    <= op;
    cmd_addr_i  <= addr;
    cmd_wdata_i <= wd;
    cmd_valid_i <= 1'b1;
    nbits = 8'h00;
    seen_mode = 1'b0;
    seen_done = 1'b0;
    @(posedge ref_clk_i);
    cmd_valid_i <= 1'b0;
    for (i = 0; i < 4000; i++)
    begin
      @(posedge ref_clk_i);
      #1;
      seen_mode = seen_mode | serial_mode_o;
      seen_done = seen_done | write_done_o;
      if (rsp_valid_o === 1'b1)
        break;
    end
    if (i == 4000)
    begin
      n_mismatch++;
      final_report();
    end
    check("bits", nbits, 8'h10);
    check("frame_hi", frame[15:8], {op, addr});
    check("frame_lo", frame[7:0], lo);
    check("mode", {7'h00, seen_mode}, 8'h01);
    check("analog", {7'h00, link.dev_analog_en}, 8'h01);
    check("idle_line", {7'h00, link.serial_data_io}, 8'h01);
    check("done", {7'h00, seen_done}, {7'h00, wr});
  endtask : run

  task automatic look(input logic [4:0] addr);
    @(posedge ref_clk_i);
    trim_rd_addr_i <= addr;
    ctrl_rd_addr_i <= addr;
    @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    #1;
  endtask : look

  task automatic t_reset();
    look(5'h1E);
    check("rst_mode", {7'h00, serial_mode_o}, 8'h00);
    check("rst_trim", trim_rd_data_o, 8'h00);
    check("rst_ctrl", ctrl_rd_data_o, 8'h00);
  endtask : t_reset

  task automatic t_trim();
    run(3'h5, 5'h03, 8'hA5, 8'hA5, 1'b1);
    look(5'h03);
    check("trim_wr", trim_rd_data_o, 8'hA5);
    run(3'h6, 5'h03, 8'h00, 8'hA5, 1'b0);
    check("trim_rd", rsp_rdata_o, 8'hA5);
  endtask : t_trim

  task automatic t_ctrl();
    run(3'h1, 5'h01, 8'h3C, 8'h3C, 1'b1);
    look(5'h01);
    check("ctrl_wr", ctrl_rd_data_o, 8'h3C);
    check("ctrl_sep", trim_rd_data_o, 8'h00);
    run(3'h2, 5'h01, 8'h00, 8'h3C, 1'b0);
    check("ctrl_rd", rsp_rdata_o, 8'h3C);
  endtask : t_ctrl

  task automatic t_bad_op();
    @(posedge ref_clk_i);
    cmd_op_i    <= 3'h7;
    cmd_addr_i  <= 5'h03;
    cmd_wdata_i <= 8'hFF;
    cmd_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    cmd_valid_i <= 1'b0;
    #1;
    check("bad_rsp", {7'h00, rsp_valid_o}, 8'h01);
    check("bad_ready", {7'h00, cmd_ready_o}, 8'h01);
    repeat (ENT + 16) @(posedge ref_clk_i);
    #1;
    check("bad_link", {6'h00, link.cfg_serial_clock_pin, serial_mode_o}, 8'h00);
    check("bad_rdata", rsp_rdata_o, 8'h3C);
    look(5'h03);
    check("bad_op", trim_rd_data_o, 8'hA5);
  endtask : t_bad_op

  task automatic t_batch();
    run(3'h5, 5'h1F, 8'h5A, 8'h5A, 1'b1);
    for (int a = 0; a < 32; a++)
    begin
      look(a[4:0]);
      check("batch", trim_rd_data_o, (a == 30) ? 8'h00 : 8'h5A);
    end
    run(3'h6, 5'h1E, 8'h00, 8'h00, 1'b0);
    check("skip_rd", rsp_rdata_o, 8'h00);
  endtask : t_batch

  // Main sequence
  initial
  begin
    resetn_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_op_i = 3'h0;
    cmd_addr_i = 5'h00;
    cmd_wdata_i = 8'h00;
    trim_rd_addr_i = 5'h00;
    ctrl_rd_addr_i = 5'h00;
    nbits = 8'h00;
    frame = 16'h0000;
    repeat (20) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_trim();
    t_ctrl();
    t_bad_op();
    t_batch();
    final_report();
  end
endmodule : tb
`default_nettype wire
